/* File: iopbd_board.sv */
// Board model that resolves the port A pin levels.
`timescale 1ns/1ps
`default_nettype none
module iopbd_board
  import iopbd_pkg::*;
(
  input wire iopbd_pad_t pad,
  input wire logic [7:0] ext_oe,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin
);
  // A driving pad wins; a released pin goes to the pull-up or a changing level.
  assign pin = pad.oe & pad.out | ~pad.oe & (ext_oe & ext_val
    | ~ext_oe & (pad.pull_en | ext_val));
endmodule
`default_nettype wire

/* File: iopbd_pfd.sv */
// Timer-overflow driven frequency divider toggle stage.
`timescale 1ns/1ps
`default_nettype none
module iopbd_pfd
  import iopbd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic timer_overflow,
  output logic pfd_level
);
  typedef struct packed {
    logic lvl;
  } iopbd_pfd_st_t;

  iopbd_pfd_st_t st_ff;
  iopbd_pfd_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (timer_overflow)
    begin
      nxt_st.lvl = ~st_ff.lvl;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  assign pfd_level = st_ff.lvl;
endmodule
`default_nettype wire

/* File: iopbd_pkg.sv */
// Package with constants and carrier types of the I/O port block.
package iopbd_pkg;
  localparam logic [7:0] IOPBD_ADDR_PORT_A = 8'h12;
  localparam logic [7:0] IOPBD_ADDR_PORT_B = 8'h14;
  localparam int IOPBD_PA_W = 8;
  localparam int IOPBD_PB_W = 6;
  localparam logic [7:0] IOPBD_PA_RESET = 8'hff;
  localparam int IOPBD_BIT_BZ = 0;
  localparam int IOPBD_BIT_BZN = 1;
  localparam int IOPBD_BIT_PFD = 3;
  localparam int IOPBD_OPT_BITS = 4;
  localparam logic [7:0] IOPBD_TMR_TOP = 8'hff;

  // ==========================================================================
  // CPU data-memory access to the port block.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iopbd_cpu_req_t;

  // Pad-side drive of port A.
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } iopbd_pad_t;
endpackage

/* File: iopbd_props.sv */
// Checker of the port block rules at the top module ports.
`timescale 1ns/1ps
`default_nettype none
module iopbd_props
  import iopbd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire iopbd_cpu_req_t cpu_req,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rvalid,
  input wire logic [7:0] port_a_in,
  input wire logic [5:0] port_b_in,
  input wire iopbd_pad_t port_a_pad,
  input wire logic timer_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic rd;
  logic wa;
  assign rd = cpu_req.rd & clk_en;
  assign wa = cpu_req.wr & clk_en & (cpu_req.addr == 8'h12);
  property p_rv; rd |=> cpu_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read unanswered");
  property p_ra; rd && cpu_req.addr == 8'h12 |=>
    cpu_rdata == $past(port_a_in); endproperty
  a_ra: assert property (p_ra) else $error("port a read");
  property p_rb; rd && cpu_req.addr == 8'h14 |=>
    cpu_rdata == {2'h0, $past(port_b_in)}; endproperty
  a_rb: assert property (p_rb) else $error("port b read");
  property p_hold; clk_en && !wa |=> $stable(port_a_pad.oe[7:4]);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_wr; wa |=>
    port_a_pad.oe[7:4] == ~$past(cpu_req.wdata[7:4]); endproperty
  a_wr: assert property (p_wr) else $error("latch write");
  property p_od; port_a_pad.out[7:4] == 4'h0 &&
    port_a_pad.pull_en[7:4] == 4'hf; endproperty
  a_od: assert property (p_od) else $error("upper pins");
  property p_bz; port_a_pad.out[1] |-> !port_a_pad.out[0]; endproperty
  a_bz: assert property (p_bz) else $error("buzzer pair");
  property p_pfd; $rose(port_a_pad.out[3]) |->
    $past(timer_on) || $past(timer_on, 2); endproperty
  a_pfd: assert property (p_pfd) else $error("divider");
endmodule
bind iopbd_top iopbd_props props_u (.clock(clock), .arst_n(arst_n),
  .clk_en(clk_en), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
  .cpu_rvalid(cpu_rvalid), .port_a_in(port_a_in), .port_b_in(port_b_in),
  .port_a_pad(port_a_pad), .timer_on(timer_on));
`default_nettype wire

/* File: iopbd_top.sv */
// Port A/B block with buzzer pair and divider output on port A pins.
// What this block does
// - Port A at 12H, port B at 14H.
// - Bits 0-3 push-pull or open-drain; 4-7 open-drain pulled.
// - Open-drain port A pins optionally wake from halt.
// - Port B is input only.
// - Reads sample pins live, not latched.
// - Port A latch holds until rewritten.
// - Reset leaves lines high except enabled buzzer and divider pins; writes set latch bits.
// - Bit operations read port, modify, write latch.
// - Port A reads return pad levels.
// - Push-pull pins act only as outputs.
// - Buzzer and divider need push-pull pin option.
// - Buzzer pair follows latch bits 0 and 1.
// - Divider out when timer on and bit3 clear.
// - Divider frequency is clock over 2(256-N).
// - Divider derived from timer overflows on pin 3.
`timescale 1ns/1ps
`default_nettype none
module iopbd_top
  import iopbd_pkg::*;
#(
  parameter logic [3:0] OPT_PUSH_PULL = 4'h0,
  parameter logic [3:0] OPT_PULLUP_LO = 4'hf,
  parameter logic [7:0] OPT_WAKE = 8'h00,
  parameter logic OPT_BUZZER = 1'b0,
  parameter logic OPT_PFD = 1'b0
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire iopbd_cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  input wire logic [7:0] port_a_in,
  input wire logic [5:0] port_b_in,
  output iopbd_pad_t port_a_pad,
  input wire logic buzzer_clk,
  input wire logic timer_on,
  input wire logic timer_overflow,
  output logic wake_req
);
  // ==========================================================================
  // State.
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_in_prev;
    logic wake;
  } iopbd_st_t;

  iopbd_st_t st_ff;
  iopbd_st_t nxt_st;
  logic pfd_level;
  logic [7:0] push_pull;
  logic [7:0] pull_en;

  // ==========================================================================
  // Pin structure options.
  assign push_pull = {4'h0, OPT_PUSH_PULL};
  assign pull_en = {4'hf, OPT_PULLUP_LO & ~OPT_PUSH_PULL};

  iopbd_pfd u_pfd
  (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .timer_overflow(timer_overflow),
    .pfd_level(pfd_level)
  );

  // ==========================================================================
  // Next state.
  always_comb
  begin
    logic [7:0] drv;
    drv = st_ff.latch;
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.wake = 1'b0;
    // A read returns live pads of port A and pins of port B.
    if (cpu_req.rd)
    begin
      nxt_st.rvalid = 1'b1;
      if (cpu_req.addr == IOPBD_ADDR_PORT_A)
      begin
        nxt_st.rdata = port_a_in;
      end
      else if (cpu_req.addr == IOPBD_ADDR_PORT_B)
      begin
        nxt_st.rdata = {2'h0, port_b_in};
      end
      else
      begin
        nxt_st.rdata = 8'h00;
      end
    end
    // Writes to port B land nowhere; the latch changes only on a write.
    if (cpu_req.wr && cpu_req.addr == IOPBD_ADDR_PORT_A)
    begin
      nxt_st.latch = cpu_req.wdata;
      drv = cpu_req.wdata;
    end
    // Shared functions only on push-pull pins.
    if (OPT_BUZZER && push_pull[IOPBD_BIT_BZ]
        && push_pull[IOPBD_BIT_BZN])
    begin
      if (drv[IOPBD_BIT_BZ])
      begin
        drv[IOPBD_BIT_BZ] = 1'b0;
        drv[IOPBD_BIT_BZN] = 1'b0;
      end
      else if (drv[IOPBD_BIT_BZN])
      begin
        drv[IOPBD_BIT_BZ] = buzzer_clk;
        drv[IOPBD_BIT_BZN] = 1'b0;
      end
      else
      begin
        drv[IOPBD_BIT_BZ] = buzzer_clk;
        drv[IOPBD_BIT_BZN] = ~buzzer_clk;
      end
    end
    if (OPT_PFD && push_pull[IOPBD_BIT_PFD])
    begin
      // With the timer off the pin is unspecified; here it is driven low.
      drv[IOPBD_BIT_PFD] = !drv[IOPBD_BIT_PFD] && timer_on
                           && pfd_level;
    end
    // Push-pull drives both levels; open-drain only pulls low.
    nxt_st.pad_out = drv & push_pull;
    nxt_st.pad_oe = push_pull | ~drv;
    // Falling edge on a wake-enabled open-drain pin.
    nxt_st.pad_in_prev = port_a_in;
    nxt_st.wake = |(st_ff.pad_in_prev & ~port_a_in & OPT_WAKE
                    & ~push_pull);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff.latch <= IOPBD_PA_RESET;
      st_ff.rdata <= 8'h00;
      st_ff.rvalid <= 1'b0;
      st_ff.pad_out <= 8'h00;
      st_ff.pad_oe <= 8'h00;
      st_ff.pad_in_prev <= 8'hff;
      st_ff.wake <= 1'b0;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  assign cpu_rdata = st_ff.rdata;
  assign cpu_rvalid = st_ff.rvalid;
  assign port_a_pad.out = st_ff.pad_out;
  assign port_a_pad.oe = st_ff.pad_oe;
  assign port_a_pad.pull_en = pull_en;
  assign wake_req = st_ff.wake;
endmodule
`default_nettype wire

/* File: test_io_port_buzzer_divider.sv */
// Self-checking bench of the port block.
`timescale 1ns/1ps
`default_nettype none
module test_io_port_buzzer_divider;
  import iopbd_pkg::*;
  logic clock = 0, arst_n = 0, clk_en = 1, bz = 0, ton = 0, ovf = 0;
  logic rvalid, wake;
  logic [7:0] rdata, pin, w, eo = 0, ev = 0, cnt = 0;
  logic [7:0] bm [4] = '{8'hfc, 8'hfe, 8'hfd, 8'hff};
  logic [5:0] pb = 0;
  iopbd_cpu_req_t req = '0;
  iopbd_pad_t pad;
  int err_total = 0, checks = 0, n;
  always #2.5 clock = ~clock;
  iopbd_top #(.OPT_PUSH_PULL(4'hb), .OPT_WAKE(8'hf4), .OPT_BUZZER(1'b1),
    .OPT_PFD(1'b1)) dut_u (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .cpu_req(req), .cpu_rdata(rdata), .cpu_rvalid(rvalid), .port_a_in(pin),
    .port_b_in(pb), .port_a_pad(pad), .buzzer_clk(bz), .timer_on(ton),
    .timer_overflow(ovf), .wake_req(wake));
  iopbd_board board_u (.pad(pad), .ext_oe(eo), .ext_val(ev), .pin(pin));
  always @(negedge clock)
  begin
    bz <= 1'($urandom);
    ovf <= ton && cnt == 8'hff;
    cnt <= (!ton || cnt == 8'hff) ? 8'hfa : cnt + 8'h1;
  end
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic r, input logic [7:0] a, d);
    @(negedge clock);
    req <= '{r, !r, a, d};
    @(negedge clock);
    req <= '0;
    if (r)
      chk({7'h0, rvalid}, 8'h1);
  endtask
  function automatic logic [7:0] exp_a(logic [7:0] d, o, v);
    logic [7:0] m;
    m = d & (~o | v);
    return {m[7:4], 1'b0, m[2], 2'h0};
  endfunction
  task automatic close_out;
    $display("counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #20000;
    err_total++;
    close_out;
  end
  initial
  begin
    void'($urandom(66478));
    repeat (12) @(negedge clock);
    arst_n = 1;
    acc(1, 8'h12, 8'h0);
    chk(rdata, 8'hf4);
    chk(pad.oe, 8'h0b);
    repeat (16)
    begin
      w = 8'($urandom) | 8'h09;
      acc(0, 8'h12, w);
      acc(0, 8'h14, ~w);
      eo = 8'($urandom) & 8'hf4;
      ev = 8'($urandom);
      pb = 6'($urandom);
      acc(1, 8'h12, 8'h0);
      chk(rdata, exp_a(w, eo, ev));
      acc(1, 8'h14, 8'h0);
      chk(rdata, {2'h0, pb});
    end
    acc(1, 8'h16, 8'h0);
    chk(rdata, 8'h0);
    $display("random test done");
    foreach (bm[i])
    begin
      acc(0, 8'h12, bm[i]);
      repeat (3)
      begin
        @(negedge clock);
        chk(pad.out, {6'h0, bm[i][1:0] == 2'h0 & ~bz, ~bm[i][0] & bz});
      end
    end
    $display("buzzer test done");
    // A falling level on released, wake-enabled pin 2 gives one wake pulse.
    eo = 8'h04;
    ev = 8'h04;
    repeat (3) @(negedge clock);
    ev = 8'h00;
    @(negedge clock);
    chk({7'h0, wake}, 8'h1);
    @(negedge clock);
    chk({7'h0, wake}, 8'h0);
    $display("wake test done");
    acc(0, 8'h12, 8'hf5);
    ton = 1;
    repeat (20) @(negedge clock);
    n = 0;
    repeat (48)
    begin
      @(negedge clock);
      n += pad.out[3];
    end
    chk(n[7:0], 8'h18);
    acc(0, 8'h12, 8'hfd);
    repeat (3) @(negedge clock);
    chk(pad.out, 8'h00);
    $display("divider test done");
    // With the clock enable low a write must not reach the pads.
    clk_en = 0;
    acc(0, 8'h12, 8'h00);
    repeat (2) @(negedge clock);
    chk(pad.oe, 8'h0b);
    clk_en = 1;
    repeat (2) @(negedge clock);
    chk(pad.oe, 8'h0b);
    $display("enable test done");
    close_out;
  end
endmodule
`default_nettype wire
